// ===== design/psc_pkg.sv
// shared constants, register map and count arithmetic for the presettable counter
package psc_pkg;

    localparam int unsigned CNT_W = 4;

    localparam logic [3:0] TERM_DECADE = 4'h9;
    localparam logic [3:0] TERM_BINARY = 4'hf;
    localparam logic [3:0] CNT_RESET   = 4'h0;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int unsigned ADDR_W     = 8;

    // control register fields
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;
    localparam logic        CTRL_RUN_RESET = 1'b1;

    // status register fields
    localparam int unsigned STAT_COUNT_LSB  = 0;
    localparam int unsigned STAT_TC_BIT     = 4;
    localparam int unsigned STAT_DECADE_BIT = 5;
    localparam int unsigned STAT_ASYNC_BIT  = 6;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] HRDATA_RESET  = 32'h0000_0000;

    function automatic logic [3:0] psc_terminal(input logic decade);
        psc_terminal = decade ? TERM_DECADE : TERM_BINARY;
    endfunction : psc_terminal

    // values above nine in decade mode keep counting in binary until 15 wraps
    function automatic logic [3:0] psc_next_count(input logic [3:0] q, input logic decade);
        if (decade && (q == TERM_DECADE))
        begin
            psc_next_count = CNT_RESET;
        end
        else
        begin
            psc_next_count = 4'(q + 4'h1);
        end
    endfunction : psc_next_count

endpackage : psc_pkg

// ===== design/psc_tc_decode.sv
// look-ahead terminal count decode, gated by the trickle enable
`timescale 1ns/10ps
module psc_tc_decode #(
    parameter bit DECADE = 1'b1
) (
    // counter state and gate
    input  wire logic [3:0] count_value,
    input  wire logic       cnt_en_trickle,
    // decoded carry
    output logic            tc
);

    assign tc = cnt_en_trickle && (count_value == psc_pkg::psc_terminal(DECADE));

endmodule : psc_tc_decode

// ===== design/psc_ahb_regs.sv
// ahb-lite slave holding the control and status words of the counter
`timescale 1ns/10ps
module psc_ahb_regs (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // counter side
    input  wire logic [31:0] status_word,
    output logic             sw_run,
    output logic             sw_clear
);

    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        next_wr_pend;
    logic [7:0]  next_wr_addr;
    logic        next_sw_run;
    logic        next_sw_clear;
    logic [31:0] next_hrdata;
    logic        addr_phase;

    assign addr_phase = hsel && hready && htrans[1];

    always_comb
    begin
        next_wr_pend  = addr_phase && hwrite;
        next_wr_addr  = haddr[7:0];
        next_sw_run   = sw_run;
        next_sw_clear = 1'b0;
        next_hrdata   = hrdata;
        if (addr_phase && !hwrite)
        begin
            unique case (haddr[7:0])
                psc_pkg::ADDR_CTRL:   next_hrdata = {30'h0, 1'b0, sw_run};
                psc_pkg::ADDR_STATUS: next_hrdata = status_word;
                default:              next_hrdata = 32'h0000_0000;
            endcase
        end
        if (wr_pend && (wr_addr == psc_pkg::ADDR_CTRL))
        begin
            next_sw_run   = hwdata[psc_pkg::CTRL_RUN_BIT];
            next_sw_clear = hwdata[psc_pkg::CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            sw_run    <= psc_pkg::CTRL_RUN_RESET;
            sw_clear  <= 1'b0;
            hrdata    <= psc_pkg::HRDATA_RESET;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            sw_run    <= next_sw_run;
            sw_clear  <= next_sw_clear;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule : psc_ahb_regs

// ===== design/psc_counter.sv
// four-bit presettable synchronous counter with ahb-lite control and status
`timescale 1ns/10ps
module psc_counter #(
    parameter bit DECADE      = 1'b1,
    parameter bit ASYNC_CLEAR = 1'b1
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // counter pins
    input  wire logic        async_clear_n,
    input  wire logic        sync_clear_n,
    input  wire logic        load_n,
    input  wire logic        cnt_en_parallel,
    input  wire logic        cnt_en_trickle,
    input  wire logic [3:0]  preset_value,
    output logic [3:0]       count_value,
    output logic             terminal_count_out
);

    logic        sw_run;
    logic        sw_clear;
    logic        clr_rst_n;
    logic        sync_clr;
    logic        count_go;
    logic [3:0]  next_count_value;
    logic        tc_dec;
    logic [31:0] status_word;

    // the async variant folds the pin into the flip-flop reset
    assign clr_rst_n = hresetn && (ASYNC_CLEAR ? async_clear_n : 1'b1);

    // a software clear acts like the synchronous clear on either variant
    assign sync_clr = (!ASYNC_CLEAR && !sync_clear_n) || sw_clear;

    assign count_go = cnt_en_parallel && cnt_en_trickle && load_n && sw_run;

    always_comb
    begin
        next_count_value = count_value;
        if (sync_clr)
        begin
            next_count_value = psc_pkg::CNT_RESET;
        end
        else if (!load_n)
        begin
            next_count_value = preset_value;
        end
        else if (count_go)
        begin
            next_count_value = psc_pkg::psc_next_count(count_value, DECADE);
        end
    end

    always_ff @(posedge hclk or negedge clr_rst_n)
    begin
        if (!clr_rst_n)
        begin
            count_value <= psc_pkg::CNT_RESET;
        end
        else
        begin
            count_value <= next_count_value;
        end
    end

    psc_tc_decode #(
        .DECADE (DECADE)
    ) u_tc (
        .count_value    (count_value),
        .cnt_en_trickle (cnt_en_trickle),
        .tc             (tc_dec)
    );

    // the carry stays combinational so trickle low drops it at once
    assign terminal_count_out = tc_dec;

    always_comb
    begin
        status_word                                = 32'h0000_0000;
        status_word[psc_pkg::STAT_COUNT_LSB +: 4]  = count_value;
        status_word[psc_pkg::STAT_TC_BIT]          = tc_dec;
        status_word[psc_pkg::STAT_DECADE_BIT]      = DECADE;
        status_word[psc_pkg::STAT_ASYNC_BIT]       = ASYNC_CLEAR;
    end

    psc_ahb_regs u_regs (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .status_word (status_word),
        .sw_run      (sw_run),
        .sw_clear    (sw_clear)
    );

    property p_load;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!load_n && !sync_clr) |=> (count_value == $past(preset_value));
    endproperty
    a_load: assert property (p_load) else $error("load did not copy preset");

    property p_load_no_enable;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!load_n && !sync_clr && !cnt_en_parallel && !cnt_en_trickle)
            |=> (count_value == $past(preset_value));
    endproperty
    a_load_no_enable: assert property (p_load_no_enable)
        else $error("load blocked by low enables");

    property p_async_clear;
        @(posedge hclk) disable iff (!hresetn)
        (ASYNC_CLEAR && !async_clear_n) |-> (count_value == psc_pkg::CNT_RESET);
    endproperty
    a_async_clear: assert property (p_async_clear) else $error("async clear not zero");

    property p_sync_clear;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!ASYNC_CLEAR && !sync_clear_n && !load_n)
            |=> (count_value == psc_pkg::CNT_RESET) ##1 1'b1;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("sync clear lost to load");

    property p_count;
        @(posedge hclk) disable iff (!clr_rst_n)
        (count_go && !sync_clr)
            |=> (count_value == psc_pkg::psc_next_count($past(count_value), DECADE));
    endproperty
    a_count: assert property (p_count) else $error("count step wrong");

    property p_hold;
        @(posedge hclk) disable iff (!clr_rst_n)
        (load_n && !sync_clr && (!cnt_en_parallel || !cnt_en_trickle))
            |=> $stable(count_value);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while held");

    property p_wrap;
        @(posedge hclk) disable iff (!clr_rst_n)
        (count_go && !sync_clr && (count_value == psc_pkg::psc_terminal(DECADE)))
            |=> (count_value == psc_pkg::CNT_RESET);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap after terminal");

    property p_tc_value;
        @(posedge hclk) disable iff (!clr_rst_n)
        terminal_count_out == (cnt_en_trickle && count_value[0] && count_value[3]
            && (DECADE ? !(count_value[1] || count_value[2])
                       : (count_value[1] && count_value[2])));
    endproperty
    a_tc_value: assert property (p_tc_value) else $error("terminal count wrong");

    property p_tc_gate;
        @(posedge hclk) disable iff (!clr_rst_n)
        !cnt_en_trickle |-> !terminal_count_out;
    endproperty
    a_tc_gate: assert property (p_tc_gate) else $error("carry high with trickle low");

    property p_tc_lsb;
        @(posedge hclk) disable iff (!clr_rst_n)
        terminal_count_out |-> count_value[0];
    endproperty
    a_tc_lsb: assert property (p_tc_lsb) else $error("carry outside bit zero high");

    property p_decade_escape;
        @(posedge hclk) disable iff (!clr_rst_n)
        (DECADE && count_go && !sync_clr && (count_value > 4'h9))
            |=> (count_value == 4'($past(count_value) + 4'h1));
    endproperty
    a_decade_escape: assert property (p_decade_escape)
        else $error("illegal decade value stuck");

    property p_decade_top_wrap;
        @(posedge hclk) disable iff (!clr_rst_n)
        (DECADE && count_go && !sync_clr && (count_value == psc_pkg::TERM_BINARY))
            |=> (count_value == psc_pkg::CNT_RESET);
    endproperty
    a_decade_top_wrap: assert property (p_decade_top_wrap)
        else $error("escaped decade value did not wrap");

    property p_decade_range;
        @(posedge hclk) disable iff (!clr_rst_n)
        (DECADE && count_go && !sync_clr && (count_value <= psc_pkg::TERM_DECADE))
            |=> (count_value <= psc_pkg::TERM_DECADE);
    endproperty
    a_decade_range: assert property (p_decade_range)
        else $error("decade count left its range");

    property p_count_moves;
        @(posedge hclk) disable iff (!clr_rst_n)
        (count_go && !sync_clr) |=> (count_value != $past(count_value));
    endproperty
    a_count_moves: assert property (p_count_moves) else $error("count stalled");

    property p_run_hold;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!sw_run && load_n && !sync_clr) |=> $stable(count_value);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

    property p_load_bits;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!load_n && !sync_clr)
            |=> (count_value[0] == $past(preset_value[0]))
                && (count_value[3] == $past(preset_value[3]));
    endproperty
    a_load_bits: assert property (p_load_bits) else $error("preset bits misplaced");

    property p_soft_clear;
        @(posedge hclk) disable iff (!clr_rst_n)
        sw_clear |=> (count_value == psc_pkg::CNT_RESET);
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft clear missed");

    property p_sync_pin_clear;
        @(posedge hclk) disable iff (!clr_rst_n)
        (!ASYNC_CLEAR && !sync_clear_n) |=> (count_value == psc_pkg::CNT_RESET);
    endproperty
    a_sync_pin_clear: assert property (p_sync_pin_clear)
        else $error("sync clear pin missed");

    property p_clear_tc;
        @(posedge hclk) disable iff (!hresetn)
        (ASYNC_CLEAR && !async_clear_n) |-> !terminal_count_out;
    endproperty
    a_clear_tc: assert property (p_clear_tc) else $error("carry high during clear");

    property p_tc_one_step;
        @(posedge hclk) disable iff (!clr_rst_n)
        (terminal_count_out && count_go && !sync_clr) |=> !terminal_count_out;
    endproperty
    a_tc_one_step: assert property (p_tc_one_step) else $error("carry pulse too long");

    property p_parallel_no_gate;
        @(posedge hclk) disable iff (!clr_rst_n)
        (cnt_en_trickle && !cnt_en_parallel
            && (count_value == psc_pkg::psc_terminal(DECADE))) |-> terminal_count_out;
    endproperty
    a_parallel_no_gate: assert property (p_parallel_no_gate)
        else $error("parallel enable gated carry");

    property p_hready;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout;
    endproperty
    a_hready: assert property (p_hready) else $error("slave inserted a wait state");

    property p_okay;
        @(posedge hclk) disable iff (!hresetn)
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("slave answered with an error");

    property p_read_ctrl;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == psc_pkg::ADDR_CTRL))
            |=> (hrdata == {31'h0000_0000, $past(sw_run)});
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

    property p_read_status;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == psc_pkg::ADDR_STATUS))
            |=> (hrdata == $past(status_word));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_read_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");

    property p_write_run;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && hwrite && (haddr[7:0] == psc_pkg::ADDR_CTRL))
            |-> ##2 (sw_run == $past(hwdata[psc_pkg::CTRL_RUN_BIT]));
    endproperty
    a_write_run: assert property (p_write_run) else $error("run bit not written");

    property p_write_clear;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && hwrite && (haddr[7:0] == psc_pkg::ADDR_CTRL))
            |-> ##2 (sw_clear == $past(hwdata[psc_pkg::CTRL_CLEAR_BIT]));
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("clear pulse not written");

endmodule : psc_counter

// ===== test/psc_cascade_stage.sv
// upper decade stage cascaded on the counter's carry
`timescale 1ns/10ps
module psc_cascade_stage (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // enables from the lower stage
    input  wire logic       cnt_en_parallel,
    input  wire logic       carry_in,
    // upper digit
    output logic [3:0]      hi_value
);
    logic [3:0] next_hi_value;

    // carry is used only as an enable, never as a clock or a reset
    always_comb
    begin
        next_hi_value = hi_value;
        if (cnt_en_parallel && carry_in)
        begin
            next_hi_value = (hi_value == 4'h9) ? 4'h0 : 4'(hi_value + 4'h1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_value <= 4'h0;
        end
        else
        begin
            hi_value <= next_hi_value;
        end
    end
endmodule : psc_cascade_stage

// ===== test/psc_counter_bench.sv
// self-checking bench for the presettable counter, decade and binary variants
`timescale 1ns/10ps
module psc_counter_bench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tc_a, tc_b, run_m;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        async_clear_n, sync_clear_n, load_n, cnt_en_parallel, cnt_en_trickle;
    logic [3:0]  preset_value, cnt_a, cnt_b, hi_value, ma, mb, hm;
    logic [8:0]  prev;
    int          error_cnt, compares, cyc;
    logic        short_en, sclr_b;
    logic [8:0]  gate_seq [0:7];

    // outside nand feeds a chosen count back to the binary stage's clear
    assign sclr_b = sync_clear_n && !(short_en && cnt_b[2] && cnt_b[1]);

    assign hready = hreadyout;

    psc_counter dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .async_clear_n(async_clear_n),
        .sync_clear_n(sync_clear_n), .load_n(load_n), .cnt_en_parallel(cnt_en_parallel),
        .cnt_en_trickle(cnt_en_trickle), .preset_value(preset_value), .count_value(cnt_a),
        .terminal_count_out(tc_a)
    );
    psc_counter #(.DECADE(1'b0), .ASYNC_CLEAR(1'b0)) dut_b (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(1'b1), .hrdata(),
        .hreadyout(), .hresp(), .async_clear_n(async_clear_n),
        .sync_clear_n(sclr_b), .load_n(load_n), .cnt_en_parallel(cnt_en_parallel),
        .cnt_en_trickle(cnt_en_trickle), .preset_value(preset_value), .count_value(cnt_b),
        .terminal_count_out(tc_b)
    );
    psc_cascade_stage upper (
        .hclk(hclk), .hresetn(hresetn), .cnt_en_parallel(cnt_en_parallel),
        .carry_in(tc_a), .hi_value(hi_value)
    );

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // pin vector: async clear, sync clear, load, parallel en, trickle en, preset[3:0]
    function automatic logic [3:0] mdl(input logic [3:0] q, input logic [8:0] p,
                                      input logic dec, input logic asy, input logic run);
        mdl = ((asy && !p[8]) || (!asy && !p[7])) ? 4'h0 : !p[6] ? p[3:0] :
              (p[5] && p[4] && run) ? ((dec && q == 4'h9) ? 4'h0 : 4'(q + 4'h1)) : q;
    endfunction : mdl

    // drive pins at an edge, then compare the state that the previous pins produced
    task automatic tick(input logic [8:0] p);
        @(posedge hclk);
        {async_clear_n, sync_clear_n, load_n, cnt_en_parallel, cnt_en_trickle, preset_value} <= p;
        if (prev[5] && prev[4] && ma == 4'h9)
            hm = (hm == 4'h9) ? 4'h0 : 4'(hm + 4'h1);
        ma = mdl(ma, prev, 1'b1, 1'b1, run_m);
        mb = mdl(mb, {prev[8], prev[7] && !(short_en && mb[2] && mb[1]), prev[6:0]},
                 1'b0, 1'b0, 1'b1);
        if (!p[8])
            ma = 4'h0;
        prev = p;
        #1;
        check("count_dec", ma, cnt_a);
        check("count_bin", mb, cnt_b);
        check("tc_dec", p[4] && ma == 4'h9, tc_a);
        check("tc_bin", p[4] && mb == 4'hf, tc_b);
        check("upper_digit", hm, hi_value);
    endtask : tick

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= psc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = {3'h0, 64'h0, 2'h0, 3'h2};
        {async_clear_n, sync_clear_n, load_n, cnt_en_parallel, cnt_en_trickle} = 5'h1c;
        preset_value = 4'h0;
        prev = 9'h1c0;
        {ma, mb, hm} = 12'h000;
        {run_m, short_en} = 2'h2;
        {error_cnt, compares, cyc} = 96'h0;
        gate_seq = '{9'h1e0, 9'h1e0, 9'h1d0, 9'h189, 9'h1c0, 9'h1d0, 9'h18f, 9'h1d0};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 8'h04, 32'h0);
        check("status", 32'h0000_0060, rd);
        ahb(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h1, rd);
        ahb(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rd);
        $display("test registers done");
        tick(9'h1b7);
        repeat (12) tick(9'h1f0);
        tick(9'h18c);
        repeat (5) tick(9'h1f0);
        $display("test count and wrap done");
        foreach (gate_seq[i])
            tick(gate_seq[i]);
        $display("test enables and gating done");
        tick(9'h185);
        tick(9'h1f0);
        tick(9'h135);
        tick(9'h0f0);
        tick(9'h0b3);
        tick(9'h1c0);
        $display("test clears done");
        tick(9'h18a);
        tick(9'h1c0);
        ahb(1'b1, 8'h00, 32'h0);
        run_m = 1'b0;
        repeat (3) tick(9'h1f0);
        tick(9'h1c0);
        ahb(1'b0, 8'h00, 32'h0);
        check("ctrl_run", 32'h0, rd);
        ahb(1'b1, 8'h00, 32'h3);
        run_m = 1'b1;
        ma = 4'h0;
        tick(9'h1c0);
        $display("test run and soft clear done");
        tick(9'h180);
        @(posedge hclk);
        short_en <= 1'b1;
        repeat (9) tick(9'h1f0);
        $display("test shortened count done");
        wrap_up();
    end
endmodule : psc_counter_bench
